// >>> verilog/bldc_pkg.sv
// shared constants, register map and decode functions for the commutation decoder
`default_nettype none
package bldc_pkg;

	// ==========================================================
	// register map (word addresses on the plain register port)
	localparam int              ADDR_W        = 4;
	localparam int              DATA_W        = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
	localparam logic [ADDR_W-1:0] REG_LINES     = 4'h1;
	localparam logic [ADDR_W-1:0] REG_POLES     = 4'h2;
	localparam logic [ADDR_W-1:0] REG_HALL_CFG  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_HALL_STEP = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h5;
	localparam logic [ADDR_W-1:0] REG_POSITION  = 4'h6;
	localparam logic [ADDR_W-1:0] REG_SPEED     = 4'h7;
	localparam logic [ADDR_W-1:0] REG_ELEC      = 4'h8;

	// ==========================================================
	// field layout
	localparam int CTRL_ENC_EN   = 0;
	localparam int CTRL_DIFF     = 1;
	localparam int CTRL_INDEX    = 2;
	localparam int CTRL_REVERSE  = 3;
	localparam int STAT_HI_LSB   = 3;
	localparam int STAT_LO_LSB   = 6;
	localparam int STAT_SRC_BIT  = 9;
	localparam int LINES_W       = 16;
	localparam int QUAD_SHIFT    = 2;
	localparam int CPR_W         = LINES_W + QUAD_SHIFT;
	localparam int PP_W          = 8;
	localparam int SPEED_W       = 16;
	localparam int CFG_W         = 4;
	localparam int STEP_W        = 3;

	// ==========================================================
	// reset values and table constants
	localparam logic [LINES_W-1:0] LINES_RESET      = 16'h0800;
	localparam logic [PP_W-1:0]    POLE_PAIRS_RESET = 8'h01;
	localparam logic [CFG_W-1:0]   CFG_RESET        = 4'h0;
	localparam logic [CFG_W-1:0]   CFG_ALT_BASE     = 4'h6;
	localparam logic [CFG_W-1:0]   CFG_LAST         = 4'hb;
	localparam logic [CFG_W-1:0]   ROWS             = 4'h6;
	localparam logic [2:0]         ROW_INVALID      = 3'h7;
	localparam logic [2:0]         ROW_LAST         = 3'h5;

	// pair = {high phase, low phase}; phase a=0, b=1, c=2
	localparam logic [5:0][3:0] STD_PAIRS = {4'h4, 4'h8, 4'h9, 4'h1, 4'h2, 4'h6};
	localparam logic [5:0][3:0] ALT_PAIRS = {4'h9, 4'h8, 4'h4, 4'h6, 4'h2, 4'h1};

	// ==========================================================
	// timing
	localparam int CLK_HZ          = 25_000_000;
	localparam int SPEED_WINDOW_US = 1000;
	localparam int SPEED_WINDOW_CYCLES = (CLK_HZ / 1_000_000) * SPEED_WINDOW_US;

	// sensor pattern to table row; 000 and 111 are no row
	function automatic logic [2:0] hall_row(input logic [2:0] h);
		case (h)
			3'h1: hall_row = 3'h0;
			3'h3: hall_row = 3'h1;
			3'h2: hall_row = 3'h2;
			3'h6: hall_row = 3'h3;
			3'h4: hall_row = 3'h4;
			3'h5: hall_row = 3'h5;
			default: hall_row = ROW_INVALID;
		endcase
	endfunction

	// step the alignment setting, wrapping inside its own family
	function automatic logic [CFG_W-1:0] cfg_advance(input logic [CFG_W-1:0] cfg,
		input logic [STEP_W-1:0] step);
		logic [CFG_W-1:0] base;
		logic [CFG_W-1:0] off;
		base = (cfg >= CFG_ALT_BASE) ? CFG_ALT_BASE : CFG_RESET;
		off  = cfg - base + {1'b0, step};
		if (off >= ROWS)
			off = off - ROWS;
		if (off >= ROWS)
			off = off - ROWS;
		cfg_advance = (cfg > CFG_LAST) ? cfg : base + off;
	endfunction

endpackage
`default_nettype wire

// >>> verilog/commutation_rom.sv
// registered commutation table lookup: sensor row and alignment to phase drive
`timescale 1ns/100ps
`default_nettype none
module commutation_rom
	import bldc_pkg::*;
(
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             rst_n_in,
	// lookup
	input  wire logic [CFG_W-1:0] cfg_in,
	input  wire logic [2:0]       hall_in,
	// phase drive, bit 0 is phase a
	output logic      [2:0]       phase_hi_out,
	output logic      [2:0]       phase_lo_out
);

	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} rom_state_t;

	rom_state_t       st_reg;
	rom_state_t       st_next;
	logic [2:0]       row;
	logic [CFG_W-1:0] idx;
	logic [3:0]       pair;
	logic             alt;

	// ==========================================================
	// lookup
	always_comb begin
		st_next = '0;
		row     = hall_row(hall_in);
		alt     = (cfg_in >= CFG_ALT_BASE);
		// each setting step moves one row, so three steps land on the swapped pair
		idx     = {1'b0, row} + (alt ? cfg_in - CFG_ALT_BASE : cfg_in);
		if (idx >= ROWS)
			idx = idx - ROWS;
		pair    = alt ? ALT_PAIRS[idx[2:0]] : STD_PAIRS[idx[2:0]];
		if (row != ROW_INVALID && cfg_in <= CFG_LAST) begin
			st_next.hi = 3'h1 << pair[3:2];
			st_next.lo = 3'h1 << pair[1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign phase_hi_out = st_reg.hi;
	assign phase_lo_out = st_reg.lo;

endmodule
`default_nettype wire

// >>> verilog/bldc_commutation_decoder.sv
// commutation decoder with hall and quadrature encoder feedback selection
`timescale 1ns/100ps
`default_nettype none
module bldc_commutation_decoder
	import bldc_pkg::*;
#(
	parameter int WINDOW_CYCLES = SPEED_WINDOW_CYCLES
)
(
	// clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_n_in,
	// register port
	input  wire logic [ADDR_W-1:0]         addr_in,
	input  wire logic [DATA_W-1:0]         wdata_in,
	input  wire logic                      wr_in,
	input  wire logic                      rd_in,
	output logic      [DATA_W-1:0]         rdata_out,
	// rotor sensors, bit 2 is sensor 1
	input  wire logic [2:0]                hall_in,
	// encoder, single-ended and differential receiver outputs
	input  wire logic                      enc_a_se_in,
	input  wire logic                      enc_b_se_in,
	input  wire logic                      enc_idx_se_in,
	input  wire logic                      enc_a_diff_in,
	input  wire logic                      enc_b_diff_in,
	input  wire logic                      enc_idx_diff_in,
	output logic                           diff_rx_en_out,
	// feedback to the loops
	output logic                           feedback_enc_out,
	output logic signed [SPEED_W-1:0]      speed_out,
	output logic      [CPR_W-1:0]          position_out,
	output logic      [CPR_W-1:0]          elec_angle_out,
	// phase drive, bit 0 is phase a
	output logic      [2:0]                phase_hi_out,
	output logic      [2:0]                phase_lo_out
);

	localparam int WIN_W = $clog2(WINDOW_CYCLES);
	localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_CYCLES - 1);
	localparam logic signed [SPEED_W-1:0] SPD_UP   = 16'sh0001;
	localparam logic signed [SPEED_W-1:0] SPD_DOWN = -16'sh0001;
	localparam int ENC_A   = 0;
	localparam int ENC_B   = 1;
	localparam int ENC_IDX = 2;

	typedef struct packed {
		logic [2:0]                hall_s1;
		logic [2:0]                hall_s2;
		logic [2:0]                enc_s1;
		logic [2:0]                enc_s2;
		logic [2:0]                enc_prev;
		logic                      enc_en;
		logic                      diff;
		logic                      use_index;
		logic                      reverse;
		logic [LINES_W-1:0]        lines;
		logic [PP_W-1:0]           pole_pairs;
		logic [CFG_W-1:0]          cfg;
		logic [CPR_W-1:0]          position;
		logic [CPR_W-1:0]          elec;
		logic [2:0]                row_prev;
		logic signed [SPEED_W-1:0] enc_acc;
		logic signed [SPEED_W-1:0] hall_acc;
		logic signed [SPEED_W-1:0] speed;
		logic [WIN_W-1:0]          win_cnt;
		logic                      rotating;
		logic [DATA_W-1:0]         rdata;
	} state_t;

	state_t                    st_reg;
	state_t                    st_next;
	logic [CPR_W-1:0]          cpr;
	logic [CPR_W:0]            e_sum;
	logic [CPR_W-1:0]          pp_ext;
	logic                      moved;
	logic                      up;
	logic                      idx_edge;
	logic                      win_tick;
	logic [2:0]                row;
	logic [2:0]                row_fwd;
	logic                      hall_step;
	logic signed [SPEED_W-1:0] enc_d;
	logic signed [SPEED_W-1:0] hall_d;

	// ==========================================================
	// table lookup
	commutation_rom u_rom (
		.ref_clk_in   (ref_clk_in),
		.rst_n_in     (rst_n_in),
		.cfg_in       (st_reg.cfg),
		.hall_in      (st_reg.hall_s2),
		.phase_hi_out (phase_hi_out),
		.phase_lo_out (phase_lo_out)
	);

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		// synchronisers; the first stage feeds only the second
		st_next.hall_s1 = hall_in;
		st_next.hall_s2 = st_reg.hall_s1;
		// receiver choice is static, so muxing ahead of the synchroniser is safe
		st_next.enc_s1  = st_reg.diff ? {enc_idx_diff_in, enc_b_diff_in, enc_a_diff_in}
			: {enc_idx_se_in, enc_b_se_in, enc_a_se_in};
		st_next.enc_s2   = st_reg.enc_s1;
		st_next.enc_prev = st_reg.enc_s2;

		// quadrature decode; a double step is an illegal jump and is dropped
		cpr      = {st_reg.lines, 2'b00};
		pp_ext   = CPR_W'(st_reg.pole_pairs);
		moved    = (st_reg.enc_s2[ENC_A] ^ st_reg.enc_prev[ENC_A])
			^ (st_reg.enc_s2[ENC_B] ^ st_reg.enc_prev[ENC_B]);
		up       = (st_reg.enc_s2[ENC_A] ^ st_reg.enc_prev[ENC_B]) ^ st_reg.reverse;
		idx_edge = st_reg.enc_s2[ENC_IDX] & ~st_reg.enc_prev[ENC_IDX];
		enc_d    = '0;
		e_sum    = '0;
		if (moved) begin
			enc_d = up ? SPD_UP : SPD_DOWN;
			if (up) begin
				st_next.position = (st_reg.position >= cpr - 1'b1) ? '0
					: st_reg.position + 1'b1;
				e_sum = {1'b0, st_reg.elec} + {1'b0, pp_ext};
				st_next.elec = (e_sum >= {1'b0, cpr}) ? CPR_W'(e_sum - {1'b0, cpr})
					: CPR_W'(e_sum);
			end else begin
				st_next.position = (st_reg.position == '0) ? cpr - 1'b1
					: st_reg.position - 1'b1;
				st_next.elec = (st_reg.elec >= pp_ext) ? st_reg.elec - pp_ext
					: st_reg.elec + cpr - pp_ext;
			end
		end
		// index only realigns the angle; a corrupted count stays corrupted
		if (idx_edge && st_reg.use_index && st_reg.enc_en && st_reg.rotating)
			st_next.elec = '0;

		// hall direction from row order
		row       = hall_row(st_reg.hall_s2);
		row_fwd   = (st_reg.row_prev == ROW_LAST) ? 3'h0 : st_reg.row_prev + 3'h1;
		hall_step = (row != ROW_INVALID) && (st_reg.row_prev != ROW_INVALID)
			&& (row != st_reg.row_prev);
		hall_d    = '0;
		if (hall_step)
			hall_d = (row == row_fwd) ? SPD_UP : SPD_DOWN;
		if (row != ROW_INVALID)
			st_next.row_prev = row;

		// speed window
		win_tick = (st_reg.win_cnt == WIN_LAST);
		if (win_tick) begin
			st_next.win_cnt  = '0;
			st_next.speed    = st_reg.enc_en ? st_reg.enc_acc : st_reg.hall_acc;
			st_next.rotating = (st_reg.enc_acc != '0);
			st_next.enc_acc  = enc_d;
			st_next.hall_acc = hall_d;
		end else begin
			st_next.win_cnt  = st_reg.win_cnt + 1'b1;
			st_next.enc_acc  = st_reg.enc_acc + enc_d;
			st_next.hall_acc = st_reg.hall_acc + hall_d;
		end

		// register writes
		if (wr_in) begin
			unique case (addr_in)
				REG_CTRL: begin
					st_next.enc_en    = wdata_in[CTRL_ENC_EN];
					st_next.diff      = wdata_in[CTRL_DIFF];
					st_next.use_index = wdata_in[CTRL_INDEX];
					st_next.reverse   = wdata_in[CTRL_REVERSE];
				end
				REG_LINES:     st_next.lines      = wdata_in[LINES_W-1:0];
				REG_POLES:     st_next.pole_pairs = wdata_in[PP_W-1:0];
				REG_HALL_CFG:  st_next.cfg        = wdata_in[CFG_W-1:0];
				REG_HALL_STEP: st_next.cfg        = cfg_advance(st_reg.cfg,
					wdata_in[STEP_W-1:0]);
				default: ;
			endcase
		end

		// register reads: data only in the cycle after the strobe
		st_next.rdata = '0;
		if (rd_in) begin
			unique case (addr_in)
				REG_CTRL: begin
					st_next.rdata[CTRL_ENC_EN]  = st_reg.enc_en;
					st_next.rdata[CTRL_DIFF]    = st_reg.diff;
					st_next.rdata[CTRL_INDEX]   = st_reg.use_index;
					st_next.rdata[CTRL_REVERSE] = st_reg.reverse;
				end
				REG_LINES:    st_next.rdata = DATA_W'(st_reg.lines);
				REG_POLES:    st_next.rdata = DATA_W'(st_reg.pole_pairs);
				REG_HALL_CFG: st_next.rdata = DATA_W'(st_reg.cfg);
				REG_STATUS: begin
					st_next.rdata[2:0] = st_reg.hall_s2;
					st_next.rdata[STAT_HI_LSB +: 3] = phase_hi_out;
					st_next.rdata[STAT_LO_LSB +: 3] = phase_lo_out;
					st_next.rdata[STAT_SRC_BIT]     = st_reg.enc_en;
				end
				REG_POSITION: st_next.rdata = DATA_W'(st_reg.position);
				REG_SPEED:    st_next.rdata = DATA_W'(st_reg.speed);
				REG_ELEC:     st_next.rdata = DATA_W'(st_reg.elec);
				default: ;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg            <= '0;
			st_reg.lines      <= LINES_RESET;
			st_reg.pole_pairs <= POLE_PAIRS_RESET;
			st_reg.cfg        <= CFG_RESET;
			st_reg.row_prev   <= ROW_INVALID;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_out        = st_reg.rdata;
	assign diff_rx_en_out   = st_reg.diff;
	assign feedback_enc_out = st_reg.enc_en;
	assign speed_out        = st_reg.speed;
	assign position_out     = st_reg.position;
	assign elec_angle_out   = st_reg.elec;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_index_seen;
		idx_edge && st_reg.use_index && st_reg.enc_en && st_reg.rotating;
	endsequence

	sequence s_step_write;
		wr_in && addr_in == REG_HALL_STEP && st_reg.cfg <= CFG_LAST;
	endsequence

	// the sensor pattern reaches the second stage two edges after it is sampled
	a_sync_two_stage: assert property (
		$past(rst_n_in, 2) |-> $past(hall_in, 2) == st_reg.hall_s2)
		else $error("hall sync is not two stages");

	a_float_invalid: assert property (
		(hall_row(st_reg.hall_s2) == ROW_INVALID || st_reg.cfg > CFG_LAST)
		|=> (phase_hi_out == 3'h0 && phase_lo_out == 3'h0))
		else $error("phases driven on invalid sensors or setting");

	a_one_hi_one_lo: assert property (
		(hall_row(st_reg.hall_s2) != ROW_INVALID && st_reg.cfg <= CFG_LAST)
		|=> ($onehot(phase_hi_out) && $onehot(phase_lo_out)
			&& (phase_hi_out & phase_lo_out) == 3'h0))
		else $error("not exactly one high and one low phase");

	a_setting0_row: assert property (
		(st_reg.cfg == CFG_RESET && st_reg.hall_s2 == 3'h1)
		|=> (phase_hi_out == 3'h2 && phase_lo_out == 3'h4))
		else $error("setting 0 first row wrong");

	a_setting3_row: assert property (
		(st_reg.cfg == 4'h3 && st_reg.hall_s2 == 3'h1)
		|=> (phase_hi_out == 3'h4 && phase_lo_out == 3'h2))
		else $error("setting 3 first row is not the swap of setting 0");

	a_setting6_row: assert property (
		(st_reg.cfg == CFG_ALT_BASE && st_reg.hall_s2 == 3'h1)
		|=> (phase_hi_out == 3'h1 && phase_lo_out == 3'h2))
		else $error("setting 6 first row wrong");

	a_family_kept: assert property (
		s_step_write |=> ((st_reg.cfg >= CFG_ALT_BASE) == ($past(st_reg.cfg) >= CFG_ALT_BASE)
			&& st_reg.cfg <= CFG_LAST))
		else $error("alignment step left its family");

	a_wrap_eleven: assert property (
		(s_step_write ##0 (st_reg.cfg == CFG_LAST && wdata_in[STEP_W-1:0] == 3'h1))
		|=> st_reg.cfg == CFG_ALT_BASE)
		else $error("setting 11 did not wrap to 6");

	a_index_resync: assert property (
		s_index_seen |=> (st_reg.elec == '0
			&& (st_reg.position == $past(st_reg.position) || $past(moved))))
		else $error("index did not clear the angle or touched the count");

	a_pos_wrap: assert property (
		(moved && up && st_reg.position == cpr - 1'b1) |=> st_reg.position == '0)
		else $error("position did not wrap at four counts per line");

	a_speed_source: assert property (
		(win_tick && !st_reg.enc_en) |=> st_reg.speed == $past(st_reg.hall_acc))
		else $error("hall speed not selected with encoder off");

	a_diff_follow: assert property (
		(wr_in && addr_in == REG_CTRL) |=> diff_rx_en_out == $past(wdata_in[CTRL_DIFF]))
		else $error("differential receiver enable not following control");

	a_feedback_src: assert property (
		(wr_in && addr_in == REG_CTRL) |=> feedback_enc_out == $past(wdata_in[CTRL_ENC_EN]))
		else $error("feedback source not following control");

	a_wrap_five: assert property (
		(s_step_write ##0 (st_reg.cfg == 4'h5 && wdata_in[STEP_W-1:0] == 3'h1))
		|=> st_reg.cfg == CFG_RESET)
		else $error("setting 5 did not wrap to 0");

	// raw direction is forward here, so only the reversal can make it count down
	a_reverse_count: assert property (
		(moved && st_reg.reverse && (st_reg.enc_s2[ENC_A] ^ st_reg.enc_prev[ENC_B])
			&& st_reg.position != '0)
		|=> st_reg.position == $past(st_reg.position) - 1'b1)
		else $error("reversed encoder did not count down");

	a_elec_scale: assert property (
		(moved && up && !(idx_edge && st_reg.use_index) && st_reg.elec < cpr - pp_ext)
		|=> st_reg.elec == $past(st_reg.elec) + $past(pp_ext))
		else $error("angle did not advance by the pole pairs");

	a_hall_forward: assert property (
		(hall_step && row == row_fwd && !win_tick)
		|=> st_reg.hall_acc == $past(st_reg.hall_acc) + SPD_UP)
		else $error("forward sensor step not counted up");

endmodule
`default_nettype wire

// >>> tb/rotor_model.sv
// sensor and encoder model standing at the motor side of the decoder
`timescale 1ns/100ps
`default_nettype none
module rotor_model (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	// motion commands, forward only, and receiver select
	input  wire logic       hall_step_in,
	input  wire logic       enc_step_in,
	input  wire logic       idx_in,
	input  wire logic       diff_rx_en_in,
	// sensor and encoder lines
	output logic      [2:0] hall_out,
	output logic            a_se_out,
	output logic            b_se_out,
	output logic            idx_se_out,
	output logic            a_diff_out,
	output logic            b_diff_out,
	output logic            idx_diff_out
);
	// ==========================================================
	// rotor state
	localparam logic [5:0][2:0] PAT = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	logic [2:0] row_reg;
	logic [1:0] quad_reg;
	logic       junk_reg;
	logic       a_w;
	logic       b_w;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			row_reg <= 3'h0;
			quad_reg <= 2'h0;
			junk_reg <= 1'b0;
		end else begin
			junk_reg <= ~junk_reg;
			if (hall_step_in)
				row_reg <= (row_reg == 3'h5) ? 3'h0 : row_reg + 3'h1;
			if (enc_step_in)
				quad_reg <= quad_reg + 2'h1;
		end
	end

	// ==========================================================
	// lines; the unused receiver shows a pattern that flips every cycle
	assign a_w = quad_reg[1] ^ quad_reg[0];
	assign b_w = quad_reg[1];
	assign hall_out = PAT[row_reg];
	assign a_diff_out = diff_rx_en_in ? a_w : junk_reg;
	assign b_diff_out = diff_rx_en_in ? b_w : junk_reg;
	assign idx_diff_out = diff_rx_en_in ? idx_in : junk_reg;
	assign a_se_out = diff_rx_en_in ? junk_reg : a_w;
	assign b_se_out = diff_rx_en_in ? junk_reg : b_w;
	assign idx_se_out = diff_rx_en_in ? junk_reg : idx_in;
endmodule
`default_nettype wire

// >>> tb/bldc_commutation_decoder_tb_top.sv
// self-checking bench for the commutation decoder
`timescale 1ns/100ps
`default_nettype none
module bldc_commutation_decoder_tb_top;
	import bldc_pkg::*;
	// ==========================================================
	// signals
	localparam int CPR = 12;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic              hs = 1'b0;
	logic              es = 1'b0;
	logic              idx = 1'b0;
	logic              frc = 1'b0;
	logic [2:0]        frc_val = 3'h0;
	wire logic [2:0]   m_hall;
	wire logic [2:0]   hall_w;
	wire logic [5:0]   enc_w;
	wire logic [31:0]  rdata;
	wire logic         fb_enc;
	wire logic         rx_en;
	wire logic signed [SPEED_W-1:0] speed;
	wire logic [CPR_W-1:0] pos;
	wire logic [CPR_W-1:0] elec;
	wire logic [2:0]   hi;
	wire logic [2:0]   lo;
	int                errors = 0;
	int                n_tests = 0;
	int                cyc = 0;
	int                cfg;
	int                h;
	int                pos_m;
	int                spd;
	logic [5:0]        prev;
	logic [31:0]       d;
	int hi_t[2][6] = '{'{1, 0, 0, 2, 2, 1}, '{0, 0, 1, 1, 2, 2}};
	int lo_t[2][6] = '{'{2, 2, 1, 1, 0, 0}, '{1, 2, 2, 0, 0, 1}};
	int row_of[8] = '{-1, 0, 2, 1, 4, 5, 3, -1};
	int starts[4] = '{0, 5, 6, 11};

	assign hall_w = frc ? frc_val : m_hall;
	always #20 clk = ~clk;

	bldc_commutation_decoder #(.WINDOW_CYCLES(16)) uut (.ref_clk_in(clk), .rst_n_in(rst_n),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.hall_in(hall_w), .enc_a_se_in(enc_w[0]), .enc_b_se_in(enc_w[1]),
		.enc_idx_se_in(enc_w[2]), .enc_a_diff_in(enc_w[3]), .enc_b_diff_in(enc_w[4]),
		.enc_idx_diff_in(enc_w[5]), .diff_rx_en_out(rx_en), .feedback_enc_out(fb_enc),
		.speed_out(speed), .position_out(pos), .elec_angle_out(elec),
		.phase_hi_out(hi), .phase_lo_out(lo));

	rotor_model model (.ref_clk_in(clk), .rst_n_in(rst_n), .hall_step_in(hs),
		.enc_step_in(es), .idx_in(idx), .diff_rx_en_in(rx_en), .hall_out(m_hall),
		.a_se_out(enc_w[0]), .b_se_out(enc_w[1]), .idx_se_out(enc_w[2]),
		.a_diff_out(enc_w[3]), .b_diff_out(enc_w[4]), .idx_diff_out(enc_w[5]));

	// ==========================================================
	// tasks and reference model
	task automatic test_done;
		$display("errors %0d of %0d checks", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask

	function automatic logic [5:0] exp_ph(input int s, input int hv);
		int r;
		r = row_of[hv];
		if (r < 0 || s > 11)
			return 6'h00;
		return {3'(1 << lo_t[s / 6][(r + s) % 6]), 3'(1 << hi_t[s / 6][(r + s) % 6])};
	endfunction

	task automatic chk_ph(input int s, input int hv);
		chk("phase", 32'(exp_ph(s, hv)), {26'h0, lo, hi});
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// one step every gap cycles, hall rotor or encoder
	task automatic move(input logic enc, input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			es <= enc;
			hs <= ~enc;
			@(posedge clk);
			es <= 1'b0;
			hs <= 1'b0;
			repeat (gap - 2) @(posedge clk);
		end
	endtask

	task automatic enc(input int n, input int gap, input int sgn);
		move(1'b1, n, gap);
		#1 spd = int'(speed);
		pos_m += sgn * n;
		repeat (4) @(posedge clk);
		#1 chk("position", 32'(((pos_m % CPR) + CPR) % CPR), 32'(pos));
		chk("elec", 32'(((pos_m * 2 % CPR) + CPR) % CPR), 32'(elec));
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			errors++;
			test_done();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		d = $urandom(20);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(REG_LINES, d);
		chk("lines", 32'h0000_0800, d);
		rd_reg(REG_POLES, d);
		chk("poles", 32'h0000_0001, d);
		wr_reg(4'hf, 32'hffff_ffff);
		rd_reg(4'hf, d);
		chk("unmapped", 32'h0, d);
		rd_reg(REG_CTRL, d);
		chk("ctrl", 32'h0, d);
		// settings 0 to 12 against every pattern, then random pairs
		frc <= 1'b1;
		for (int i = 0; i < 128; i++) begin
			cfg = (i < 104) ? i / 8 : $urandom % 16;
			h = (i < 104) ? i % 8 : $urandom % 8;
			wr_reg(REG_HALL_CFG, 32'(cfg));
			frc_val <= 3'(h);
			repeat (4) @(posedge clk);
			#1 chk_ph(cfg, h);
		end
		// rotation, family wrap and half-turn swap
		frc <= 1'b0;
		foreach (starts[j]) begin
			cfg = starts[j];
			wr_reg(REG_HALL_CFG, 32'(cfg));
			repeat (3) @(posedge clk);
			#1 prev = {lo, hi};
			move(1'b0, 1, 2);
			@(posedge clk);
			#1 chk("sync hold", 32'(prev), {26'h0, lo, hi});
			for (int k = 0; k < 7; k++) begin
				move(1'b0, 1, 5);
				#1 chk_ph(cfg, int'(hall_w));
			end
			for (int k = 1; k <= 3; k += 2) begin
				prev = {lo, hi};
				wr_reg(REG_HALL_STEP, 32'(k));
				cfg = (cfg / 6) * 6 + (cfg % 6 + k) % 6;
				repeat (3) @(posedge clk);
				#1 chk_ph(cfg, int'(hall_w));
				rd_reg(REG_HALL_CFG, d);
				chk("cfg", 32'(cfg), d);
			end
			chk("swap", 32'({prev[2:0], prev[5:3]}), {26'h0, lo, hi});
		end
		move(1'b0, 12, 4);
		#1 chk("hall speed", 32'h1, 32'(speed >= 3 && speed <= 5));
		chk("src", 32'h0, 32'(fb_enc));
		// encoder with a short line count; even net steps before each receiver switch
		wr_reg(REG_LINES, 32'h3);
		wr_reg(REG_POLES, 32'h2);
		wr_reg(REG_CTRL, 32'h1);
		pos_m = 0;
		enc(14, 4, 1);
		chk("enc speed", 32'h1, 32'(spd >= 3 && spd <= 5));
		chk("src", 32'h1, 32'(fb_enc));
		wr_reg(REG_CTRL, 32'h9);
		enc(12, 4, -1);
		chk("rev speed", 32'h1, 32'(spd >= -5 && spd <= -3));
		wr_reg(REG_CTRL, 32'h3);
		@(posedge clk);
		#1 chk("rx en", 32'h1, 32'(rx_en));
		enc(8, 4, 1);
		wr_reg(REG_CTRL, 32'h5);
		enc(10, 2, 1);
		idx <= 1'b1;
		repeat (2) @(posedge clk);
		idx <= 1'b0;
		repeat (6) @(posedge clk);
		#1 chk("index elec", 32'h0, 32'(elec));
		chk("index pos", 32'(pos_m % CPR), 32'(pos));
		rd_reg(REG_STATUS, d);
		chk("status", 32'({1'b1, exp_ph(cfg, int'(hall_w)), hall_w}), d);
		rd_reg(REG_POSITION, d);
		chk("position reg", 32'(pos_m % CPR), d);
		rd_reg(REG_ELEC, d);
		chk("angle reg", 32'h0, d);
		rd_reg(REG_CTRL, d);
		chk("ctrl reg", 32'h5, d);
		test_done();
	end
endmodule
`default_nettype wire
